/* verilog/hsn_pkg.sv */
// constants and types shared by the handshake negotiation block
package hsn_pkg;

  // register word indices; byte address is four times the index
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LCAP = 4'h1;
  localparam logic [3:0] REG_CL   = 4'h2;
  localparam logic [3:0] REG_CLR  = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MS   = 4'h5;

  // control register bits
  localparam int CTRL_START   = 0;
  localparam int CTRL_RECOVER = 1;
  localparam int CTRL_PREF_US = 2;
  localparam int CTRL_ADV     = 3;

  // local capability register layout
  localparam int LCAP_NP_LSB = 0;
  localparam int LCAP_CE     = 3;
  localparam int LCAP_TS_LSB = 4;
  localparam int LCAP_CL_LSB = 8;

  // second-level plain bits
  localparam int NP_US  = 0;
  localparam int NP_DS  = 1;
  localparam int NP_EOC = 2;

  // second-level selection bits
  localparam int SP_USED_US = 0;
  localparam int SP_USED_DS = 1;
  localparam int SP_TSIZE   = 2;
  localparam int SP_CELEN   = 3;
  localparam int SP_RFI     = 4;

  // reset values
  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [15:0] LCAP_RST = 16'h0000;

  // message word as stored and read back
  typedef struct packed {
    logic [7:0] celen;
    logic [3:0] tsize;
    logic [4:0] spar2;
    logic [2:0] npar2;
  } hsn_msg_t;

  localparam hsn_msg_t MSG_RST = '0;

  // remote-side handshake states, gray along the usual path
  typedef enum logic [1:0] {
    ST_SILENT    = 2'b00,
    ST_INIT      = 2'b01,
    ST_HANDSHAKE = 2'b11,
    ST_QUIET     = 2'b10
  } hsn_state_t;

endpackage

/* verilog/hsn_ms_enc.sv */
// mode-select field encoder from stored capability lists
`timescale 1ns/100ps
`default_nettype none
module hsn_ms_enc (
  // stored lists
  input  wire hsn_pkg::hsn_msg_t cl,
  input  wire hsn_pkg::hsn_msg_t clr,
  input  wire logic              pref_us,
  // encoded message
  output hsn_pkg::hsn_msg_t      ms
);

  logic [2:0] both;

  always_comb begin
    both = cl.npar2 & clr.npar2;
    ms = hsn_pkg::MSG_RST;
    ms.npar2[hsn_pkg::NP_EOC] = both[hsn_pkg::NP_EOC];
    if (both[hsn_pkg::NP_US] && both[hsn_pkg::NP_DS]) begin
      ms.npar2[hsn_pkg::NP_US] = pref_us;
      ms.npar2[hsn_pkg::NP_DS] = !pref_us;
    end else begin
      ms.npar2[hsn_pkg::NP_US] = both[hsn_pkg::NP_US];
      ms.npar2[hsn_pkg::NP_DS] = both[hsn_pkg::NP_DS];
    end
    ms.spar2[hsn_pkg::SP_USED_US] = 1'b0;
    ms.spar2[hsn_pkg::SP_USED_DS] = 1'b0;
    ms.spar2[hsn_pkg::SP_RFI]     = 1'b0;
    ms.spar2[hsn_pkg::SP_TSIZE]   = 1'b1;
    ms.tsize = (cl.tsize < clr.tsize) ? cl.tsize : clr.tsize;
    ms.spar2[hsn_pkg::SP_CELEN] = cl.spar2[hsn_pkg::SP_CELEN] &
                                  clr.spar2[hsn_pkg::SP_CELEN];
    if (ms.spar2[hsn_pkg::SP_CELEN]) begin
      ms.celen = (cl.celen < clr.celen) ? cl.celen : clr.celen;
    end
  end

endmodule
`default_nettype wire

/* verilog/hsn_rfsm.sv */
// remote-side handshake entry and exit state machine
`timescale 1ns/100ps
`default_nettype none
module hsn_rfsm (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // events
  input  wire logic         to_silent,
  input  wire logic         start_cmd,
  input  wire logic         hs_done,
  input  wire logic         hs_mode_sel,
  // state outputs
  output hsn_pkg::hsn_state_t state,
  output logic              init_reset,
  output logic              quiet_state
);

  typedef struct packed {
    hsn_pkg::hsn_state_t st;
    logic                rst_pls;
    logic                quiet;
  } hsn_fsm_t;

  hsn_fsm_t q_ff;
  hsn_fsm_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.rst_pls = 1'b0;
    if (to_silent) begin
      nxt_q.st = hsn_pkg::ST_SILENT;
    end else begin
      unique case (q_ff.st)
        hsn_pkg::ST_SILENT: begin
          if (start_cmd) begin
            nxt_q.st = hsn_pkg::ST_INIT;
            nxt_q.rst_pls = 1'b1;
          end
        end
        hsn_pkg::ST_INIT: begin
          nxt_q.st = hsn_pkg::ST_HANDSHAKE;
        end
        hsn_pkg::ST_HANDSHAKE: begin
          if (hs_done) begin
            nxt_q.st = hs_mode_sel ? hsn_pkg::ST_QUIET
                                   : hsn_pkg::ST_SILENT;
          end
        end
        hsn_pkg::ST_QUIET: begin
          nxt_q.st = hsn_pkg::ST_QUIET;
        end
      endcase
    end
    nxt_q.quiet = (nxt_q.st == hsn_pkg::ST_QUIET);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= '{st: hsn_pkg::ST_SILENT, rst_pls: 1'b0, quiet: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign state       = q_ff.st;
  assign init_reset  = q_ff.rst_pls;
  assign quiet_state = q_ff.quiet;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cmd;
    q_ff.st == hsn_pkg::ST_SILENT && start_cmd && !to_silent;
  endsequence
  sequence s_entry;
    init_reset && state == hsn_pkg::ST_INIT;
  endsequence

  a_start_entry: assert property (
    s_cmd |=> s_entry ##1 (state == hsn_pkg::ST_HANDSHAKE || $past(to_silent)))
    else $error("start command did not run init reset");
  a_silent_hold: assert property (
    (state == hsn_pkg::ST_SILENT && !start_cmd) |=>
      state == hsn_pkg::ST_SILENT)
    else $error("left silent state without command");
  a_loss_silent: assert property (
    to_silent |=> state == hsn_pkg::ST_SILENT && !init_reset)
    else $error("loss or error did not return to silent");
  a_quiet_exit: assert property (
    (state == hsn_pkg::ST_HANDSHAKE && hs_done && hs_mode_sel && !to_silent)
      |=> quiet_state && state == hsn_pkg::ST_QUIET)
    else $error("selected mode did not reach quiet");

endmodule
`default_nettype wire

/* verilog/hsn_top.sv */
// handshake capability negotiation block with register slave
//
// Contract
// - mode-select used-band and interference bits zero
// - transform bit one, largest common size
// - extension bit zero if either list zero
// - extension bit one only if both one
// - power-up, loss, error enter silent state
// - host command starts init reset procedure
// - selected mode ends handshake in quiet
// - capability response sets this mode's bit
// - each set selection bit carries its field
// - optional band bits only if usable
// - management channel bit only if supported
// - band and channel bits need both lists
`timescale 1ns/100ps
`default_nettype none
module hsn_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // line events
  input  wire logic        line_los,
  input  wire logic        init_err,
  // received capability lists
  input  wire logic        rx_valid,
  input  wire logic        rx_is_clr,
  input  wire logic [2:0]  rx_npar2,
  input  wire logic [4:0]  rx_spar2,
  input  wire logic [3:0]  rx_tsize,
  input  wire logic [7:0]  rx_celen,
  // handshake engine status
  input  wire logic        hs_done,
  input  wire logic        hs_mode_sel,
  // mode-select message fields
  output logic [2:0]       ms_npar2,
  output logic [4:0]       ms_spar2,
  output logic [4:0]       ms_npar3_present,
  output logic [3:0]       ms_tsize,
  output logic [7:0]       ms_celen,
  // capability-list response fields
  output logic             clr_spar1,
  output logic [2:0]       clr_npar2,
  output logic [4:0]       clr_spar2,
  output logic [4:0]       clr_npar3_present,
  output logic [3:0]       clr_tsize,
  output logic [7:0]       clr_celen,
  // remote-side state
  output logic             init_reset,
  output logic [1:0]       hs_state,
  output logic             quiet_state
);

  typedef struct packed {
    logic              wait_req;
    logic [31:0]       rdata;
    logic [1:0]        ctrl;
    logic              start;
    logic              recover;
    logic [15:0]       lcap;
    hsn_pkg::hsn_msg_t cl;
    hsn_pkg::hsn_msg_t clr;
    hsn_pkg::hsn_msg_t ms;
    hsn_pkg::hsn_msg_t rsp;
    logic              spar1;
  } hsn_top_t;

  hsn_top_t            q_ff;
  hsn_top_t            nxt_q;
  hsn_pkg::hsn_msg_t   ms_calc;
  hsn_pkg::hsn_state_t st;
  logic                quiet_w;
  logic                rst_w;
  logic                acc_wr;
  logic                req_new;

  // mode-select encoder
  hsn_ms_enc u_ms (
    .cl      (q_ff.cl),
    .clr     (q_ff.clr),
    .pref_us (q_ff.ctrl[0]),
    .ms      (ms_calc)
  );

  // remote-side state machine
  hsn_rfsm u_fsm (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .to_silent   (line_los | init_err | q_ff.recover),
    .start_cmd   (q_ff.start),
    .hs_done     (hs_done),
    .hs_mode_sel (hs_mode_sel),
    .state       (st),
    .init_reset  (rst_w),
    .quiet_state (quiet_w)
  );

  assign req_new = (avs_read | avs_write) & q_ff.wait_req;
  assign acc_wr  = avs_write & !q_ff.wait_req;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.start   = 1'b0;
    nxt_q.recover = 1'b0;
    // one-cycle answer: waitrequest drops the cycle after a new request
    nxt_q.wait_req = !req_new;
    if (req_new && avs_read) begin
      case (avs_address)
        hsn_pkg::REG_CTRL: nxt_q.rdata = {28'h0, q_ff.ctrl, 2'h0};
        hsn_pkg::REG_LCAP: nxt_q.rdata = {16'h0, q_ff.lcap};
        hsn_pkg::REG_CL:   nxt_q.rdata = {12'h0, q_ff.cl};
        hsn_pkg::REG_CLR:  nxt_q.rdata = {12'h0, q_ff.clr};
        hsn_pkg::REG_STAT: nxt_q.rdata = {28'h0, rst_w, quiet_w, st};
        hsn_pkg::REG_MS:   nxt_q.rdata = {12'h0, q_ff.ms};
        default:           nxt_q.rdata = 32'h0;
      endcase
    end
    if (acc_wr && avs_address == hsn_pkg::REG_CTRL) begin
      nxt_q.start   = avs_writedata[hsn_pkg::CTRL_START];
      nxt_q.recover = avs_writedata[hsn_pkg::CTRL_RECOVER];
      nxt_q.ctrl    = avs_writedata[hsn_pkg::CTRL_ADV:hsn_pkg::CTRL_PREF_US];
    end
    if (acc_wr && avs_address == hsn_pkg::REG_LCAP) begin
      nxt_q.lcap = avs_writedata[15:0];
    end
    // latest received lists
    if (rx_valid) begin
      if (rx_is_clr) begin
        nxt_q.clr = '{celen: rx_celen, tsize: rx_tsize,
                      spar2: rx_spar2, npar2: rx_npar2};
      end else begin
        nxt_q.cl = '{celen: rx_celen, tsize: rx_tsize,
                     spar2: rx_spar2, npar2: rx_npar2};
      end
    end
    nxt_q.ms = ms_calc;
    // capability-list response from local capabilities
    nxt_q.spar1 = q_ff.ctrl[1];
    nxt_q.rsp.npar2 = q_ff.lcap[hsn_pkg::LCAP_NP_LSB +: 3];
    nxt_q.rsp.spar2 = '0;
    nxt_q.rsp.spar2[hsn_pkg::SP_TSIZE] = 1'b1;
    nxt_q.rsp.spar2[hsn_pkg::SP_CELEN] = q_ff.lcap[hsn_pkg::LCAP_CE];
    nxt_q.rsp.tsize = q_ff.lcap[hsn_pkg::LCAP_TS_LSB +: 4];
    nxt_q.rsp.celen = q_ff.lcap[hsn_pkg::LCAP_CE]
                    ? q_ff.lcap[hsn_pkg::LCAP_CL_LSB +: 8] : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= '{wait_req: 1'b1, rdata: 32'h0, ctrl: hsn_pkg::CTRL_RST,
                start: 1'b0, recover: 1'b0, lcap: hsn_pkg::LCAP_RST,
                cl: hsn_pkg::MSG_RST, clr: hsn_pkg::MSG_RST,
                ms: hsn_pkg::MSG_RST, rsp: hsn_pkg::MSG_RST,
                spar1: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign avs_readdata      = q_ff.rdata;
  assign avs_waitrequest   = q_ff.wait_req;
  assign ms_npar2          = q_ff.ms.npar2;
  assign ms_spar2          = q_ff.ms.spar2;
  assign ms_npar3_present  = q_ff.ms.spar2;
  assign ms_tsize          = q_ff.ms.tsize;
  assign ms_celen          = q_ff.ms.celen;
  assign clr_spar1         = q_ff.spar1;
  assign clr_npar2         = q_ff.rsp.npar2;
  assign clr_spar2         = q_ff.rsp.spar2;
  assign clr_npar3_present = q_ff.rsp.spar2;
  assign clr_tsize         = q_ff.rsp.tsize;
  assign clr_celen         = q_ff.rsp.celen;
  assign init_reset        = rst_w;
  assign hs_state          = st;
  assign quiet_state       = quiet_w;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rx_cl;
    rx_valid && !rx_is_clr;
  endsequence
  sequence s_rx_clr;
    rx_valid && rx_is_clr;
  endsequence

  a_ms_zero_bits: assert property (
    ms_spar2[hsn_pkg::SP_USED_US] == 1'b0 &&
    ms_spar2[hsn_pkg::SP_USED_DS] == 1'b0 &&
    ms_spar2[hsn_pkg::SP_RFI] == 1'b0)
    else $error("mode-select band bits not zero");
  a_ms_tsize: assert property (
    !sys_rst |=> (ms_spar2[hsn_pkg::SP_TSIZE] &&
      ms_npar3_present[hsn_pkg::SP_TSIZE]
      && ms_tsize == (($past(q_ff.cl.tsize) < $past(q_ff.clr.tsize))
                      ? $past(q_ff.cl.tsize) : $past(q_ff.clr.tsize))))
    else $error("mode-select transform size not common largest");
  a_ms_ce_zero: assert property (
    (!q_ff.cl.spar2[hsn_pkg::SP_CELEN] || !q_ff.clr.spar2[hsn_pkg::SP_CELEN])
      |=> !ms_spar2[hsn_pkg::SP_CELEN] && ms_celen == 8'h00)
    else $error("extension bit set without both lists");
  a_ms_ce_one: assert property (
    (q_ff.cl.spar2[hsn_pkg::SP_CELEN] && q_ff.clr.spar2[hsn_pkg::SP_CELEN])
      |=> ms_spar2[hsn_pkg::SP_CELEN] && ms_npar3_present[hsn_pkg::SP_CELEN]
          && ms_celen != 8'h00 || $past(q_ff.cl.celen) == 8'h00
          || $past(q_ff.clr.celen) == 8'h00)
    else $error("extension bit clear though both lists set");
  a_ms_both_lists: assert property (
    ##1 ((ms_npar2 & ~($past(q_ff.cl.npar2) & $past(q_ff.clr.npar2)))
          == 3'h0 && !(ms_npar2[hsn_pkg::NP_US] && ms_npar2[hsn_pkg::NP_DS])))
    else $error("mode-select bit set without both lists");
  a_clr_advertise: assert property (
    ##1 (clr_spar1 == $past(q_ff.ctrl[1])))
    else $error("response mode bit does not follow enable");
  a_clr_fields: assert property (
    !$past(sys_rst) |-> clr_npar3_present == clr_spar2 &&
    clr_spar2[hsn_pkg::SP_TSIZE] &&
    (clr_spar2[hsn_pkg::SP_CELEN] || clr_celen == 8'h00))
    else $error("response field presence mismatch");
  a_clr_band: assert property (
    ##1 ((clr_npar2[1:0] & ~$past(q_ff.lcap[1:0])) == 2'h0))
    else $error("band bit advertised without capability");
  a_clr_eoc: assert property (
    ##1 (clr_npar2[hsn_pkg::NP_EOC] ==
         $past(q_ff.lcap[hsn_pkg::LCAP_NP_LSB + hsn_pkg::NP_EOC])))
    else $error("management channel bit wrong");
  a_store_cl: assert property (
    s_rx_cl |=> q_ff.cl.npar2 == $past(rx_npar2) &&
                q_ff.cl.spar2 == $past(rx_spar2))
    else $error("received list not stored");
  a_store_clr: assert property (
    s_rx_clr |=> q_ff.clr.npar2 == $past(rx_npar2) &&
                 q_ff.clr.tsize == $past(rx_tsize))
    else $error("received response not stored");
  a_bus_answer: assert property (
    (req_new) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_start_path: assert property (
    (acc_wr && avs_address == hsn_pkg::REG_CTRL &&
     avs_writedata[hsn_pkg::CTRL_START] && st == hsn_pkg::ST_SILENT &&
     !line_los && !init_err && !avs_writedata[hsn_pkg::CTRL_RECOVER])
      |=> ##1 (init_reset || $past(line_los) || $past(init_err)))
    else $error("start write did not start handshake");

endmodule
`default_nettype wire

/* tb/hsn_peer.sv */
// peer modem handshake model driving received lists and handshake end
`timescale 1ns/100ps
`default_nettype none
module hsn_peer (
  // clock
  input  wire logic  clk,
  // received list
  output logic       rx_valid,
  output logic       rx_is_clr,
  output logic [2:0] rx_npar2,
  output logic [4:0] rx_spar2,
  output logic [3:0] rx_tsize,
  output logic [7:0] rx_celen,
  // handshake end
  output logic       hs_done,
  output logic       hs_mode_sel
);
  initial begin
    {rx_valid, hs_done, hs_mode_sel} = 3'h0;
    {rx_is_clr, rx_celen, rx_tsize, rx_spar2, rx_npar2} = 21'h0;
  end

  // one list pulse, then inverted junk on the data lines
  task automatic send(input logic c, input logic [19:0] w);
    rx_valid <= 1'b1;
    {rx_is_clr, rx_celen, rx_tsize, rx_spar2, rx_npar2} <= {c, w};
    @(posedge clk);
    rx_valid <= 1'b0;
    {rx_is_clr, rx_celen, rx_tsize, rx_spar2, rx_npar2} <= ~{c, w};
    @(posedge clk);
  endtask

  // handshake conclusion with or without this mode selected
  task automatic conclude(input logic sel);
    hs_done <= 1'b1;
    hs_mode_sel <= sel;
    @(posedge clk);
    hs_done <= 1'b0;
    hs_mode_sel <= ~sel;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/tb_dsl_handshake_capability_negotiation.sv */
// self-checking bench for the handshake negotiation block
`timescale 1ns/100ps
`default_nettype none
module tb_dsl_handshake_capability_negotiation;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        line_los = 1'b0;
  logic        init_err = 1'b0;
  logic        rx_valid, rx_is_clr, hs_done, hs_mode_sel;
  logic [2:0]  rx_npar2, ms_npar2, clr_npar2;
  logic [4:0]  rx_spar2, ms_spar2, clr_spar2;
  logic [4:0]  ms_npar3_present, clr_npar3_present;
  logic [3:0]  rx_tsize, ms_tsize, clr_tsize;
  logic [7:0]  rx_celen, ms_celen, clr_celen;
  logic        clr_spar1, init_reset, quiet_state;
  logic [1:0]  hs_state;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [19:0] cl_w [5] = '{20'h308FF, 20'h308FF, 20'h10321, 20'h09662,
                            20'h11A66};
  logic [19:0] clr_w [5] = '{20'h20567, 20'h20567, 20'h40763, 20'h50224,
                             20'h77C66};
  logic        pf [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  hsn_top dut_u (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .line_los, .init_err, .rx_valid,
    .rx_is_clr, .rx_npar2, .rx_spar2, .rx_tsize, .rx_celen, .hs_done,
    .hs_mode_sel, .ms_npar2, .ms_spar2, .ms_npar3_present, .ms_tsize,
    .ms_celen, .clr_spar1, .clr_npar2, .clr_spar2, .clr_npar3_present,
    .clr_tsize, .clr_celen, .init_reset, .hs_state, .quiet_state
  );

  hsn_peer peer_u (
    .clk, .rx_valid, .rx_is_clr, .rx_npar2, .rx_spar2, .rx_tsize,
    .rx_celen, .hs_done, .hs_mode_sel
  );

  always #25 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one bus access, held until waitrequest samples low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // expected mode-select word from two stored lists
  function automatic logic [19:0] em(logic [19:0] a, b, logic p);
    logic [2:0] n;
    logic       ce;
    logic [3:0] t;
    logic [7:0] e;
    n = a[2:0] & b[2:0];
    if (n[1:0] == 2'b11) n[1:0] = p ? 2'b01 : 2'b10;
    ce = a[6] & b[6];
    t = (a[11:8] < b[11:8]) ? a[11:8] : b[11:8];
    e = !ce ? 8'h00 : (a[19:12] < b[19:12]) ? a[19:12] : b[19:12];
    return {e, t, 1'b0, ce, 1'b1, 2'b00, n};
  endfunction

  task automatic t_idle;
    repeat (8) begin
      @(posedge clk);
      chk("init_reset", 32'h0, init_reset);
    end
    chk("hs_state", 32'h0, hs_state);
    chk("ms_spar2", 32'h04, ms_spar2);
    chk("ms_npar3_present", 32'h04, ms_npar3_present);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, hsn_pkg::REG_LCAP, 32'h0000A5C7);
    bus(1'b0, hsn_pkg::REG_LCAP, 32'h0);
    chk("lcap", 32'h0000A5C7, rd);
  endtask

  task automatic t_clr;
    bus(1'b1, hsn_pkg::REG_LCAP, 32'h00003C9D);
    bus(1'b1, hsn_pkg::REG_CTRL, 32'h8);
    repeat (2) @(posedge clk);
    chk("clr_spar1", 32'h1, clr_spar1);
    chk("clr_npar2", 32'h5, clr_npar2);
    chk("clr_spar2", 32'h0C, clr_spar2);
    chk("clr_npar3_present", 32'h0C, clr_npar3_present);
    chk("clr_tsize", 32'h9, clr_tsize);
    chk("clr_celen", 32'h3C, clr_celen);
    bus(1'b1, hsn_pkg::REG_LCAP, 32'h00000042);
    bus(1'b1, hsn_pkg::REG_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("clr_spar1", 32'h0, clr_spar1);
    chk("clr_npar2", 32'h2, clr_npar2);
    chk("clr_spar2", 32'h04, clr_spar2);
    chk("clr_npar3_present", 32'h04, clr_npar3_present);
  endtask

  task automatic t_ms;
    logic [19:0] x;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, hsn_pkg::REG_CTRL, {29'h0, pf[i], 2'b00});
      peer_u.send(1'b0, cl_w[i]);
      peer_u.send(1'b1, clr_w[i]);
      repeat (3) @(posedge clk);
      x = em(cl_w[i], clr_w[i], pf[i]);
      chk("ms_npar2", x[2:0], ms_npar2);
      chk("ms_spar2", x[7:3], ms_spar2);
      chk("ms_npar3_present", x[7:3], ms_npar3_present);
      chk("ms_tsize", x[11:8], ms_tsize);
      chk("ms_celen", x[19:12], ms_celen);
      bus(1'b0, hsn_pkg::REG_MS, 32'h0);
      chk("ms_reg", x, rd);
      bus(1'b0, hsn_pkg::REG_CLR, 32'h0);
      chk("clr_reg", clr_w[i], rd);
    end
    bus(1'b1, hsn_pkg::REG_CL, 32'hFFFFF);
    bus(1'b0, hsn_pkg::REG_CL, 32'h0);
    chk("cl_reg", cl_w[4], rd);
  endtask

  task automatic hs_start;
    int n = 0;
    bus(1'b1, hsn_pkg::REG_CTRL, 32'h1);
    while (init_reset !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("init_reset", 32'h1, init_reset);
    chk("hs_state", 32'h1, hs_state);
    @(posedge clk);
    chk("hs_state", 32'h3, hs_state);
  endtask

  task automatic settle(input logic [1:0] st);
    repeat (2) @(posedge clk);
    chk("hs_state", {30'h0, st}, hs_state);
    chk("quiet_state", {31'h0, st == 2'b10}, quiet_state);
  endtask

  task automatic t_fsm;
    hs_start();
    peer_u.conclude(1'b1);
    settle(2'b10);
    bus(1'b0, hsn_pkg::REG_STAT, 32'h0);
    chk("stat", 32'h6, rd);
    line_los <= 1'b1;
    @(posedge clk);
    line_los <= 1'b0;
    settle(2'b00);
    hs_start();
    peer_u.conclude(1'b0);
    settle(2'b00);
    hs_start();
    init_err <= 1'b1;
    @(posedge clk);
    init_err <= 1'b0;
    settle(2'b00);
    hs_start();
    bus(1'b1, hsn_pkg::REG_CTRL, 32'h2);
    settle(2'b00);
  endtask

  // reset in mid-run from the quiet state
  task automatic t_rst;
    hs_start();
    peer_u.conclude(1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("hs_state", 32'h0, hs_state);
    chk("waitrequest", 32'h1, avs_waitrequest);
    chk("clr_spar2", 32'h0, clr_spar2);
    sys_rst <= 1'b0;
    settle(2'b00);
    chk("ms_spar2", 32'h04, ms_spar2);
    chk("init_reset", 32'h0, init_reset);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    chk("hs_state", 32'h0, hs_state);
    chk("waitrequest", 32'h1, avs_waitrequest);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_idle();
    t_clr();
    t_ms();
    t_fsm();
    t_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
